// [shared/device_status_regs.vh]
// Register map, field positions and fixed values of the device status block
`ifndef DEVICE_STATUS_REGS_VH
`define DEVICE_STATUS_REGS_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define DEVICE_STATUS_ADDR      32'h02a80000
`define DEVICE_STATUS_ADDR_W    32
`define DATA_W                  32

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DS_RSVD_HI_MSB          31
`define DS_RSVD_HI_LSB          23
`define DS_EXT_MEM_PINS_ON      22
`define DS_SDRAM_CTRL_PINS_ON   21
`define DS_PCI_PIN_SELECT       20
`define DS_CONFIG_GP_MSB        19
`define DS_CONFIG_GP_LSB        17
`define DS_RSVD_ONE_HI          16
`define DS_CLOCK_OUT_PIN_SELECT 15
`define DS_SERIAL_PORT1_PINS_ON 14
`define DS_PCI_FAST_CLOCK       13
`define DS_RSVD_ZERO_12         12
`define DS_PCI_EEPROM_AUTOINIT  11
`define DS_MAC_SEL_MSB          10
`define DS_MAC_SEL_LSB          9
`define DS_RSVD_ONE_LO          8
`define DS_RSVD_ZERO_7          7
`define DS_LITTLE_ENDIAN_FLAG   6
`define DS_HOST_PORT_WIDTH      5
`define DS_EXT_MEM_CLOCK_SELECT 4
`define DS_BOOT_SEL_MSB         3
`define DS_BOOT_SEL_LSB         0

// ----------------------------------------
// Strap vector layout and reset values
// ----------------------------------------
`define STRAP_W                 19
`define STRAP_RESET             19'h00040
`define SETTLE_CYCLES           3'h4
`define RSVD_HI_VALUE           9'h000
`define RSVD_ONE_VALUE          1'h1
`define RSVD_ZERO_VALUE         1'h0

// ----------------------------------------
// AHB encodings
// ----------------------------------------
`define HTRANS_NONSEQ_BIT       1
`define HRESP_OKAY              1'h0
`define READ_ZERO               32'h00000000

`endif

// [logic/strap_sync.v]
// Three-stage synchroniser for one strap input
module strap_sync (
  // Clock and reset
  input  wire hclk,
  input  wire hresetn,
  // Pin and result
  input  wire pin_in,
  output wire level_out,
  output wire stable_out
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign level_out  = s2_reg;
  assign stable_out = (s2_reg == s3_reg);

endmodule

// [logic/strap_capture.v]
// Strap capture: follows pins while reset is held, freezes on release
`include "device_status_regs.vh"

module strap_capture #(
  parameter WIDTH = `STRAP_W
) (
  // Clock and resets
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             dev_reset_active,
  // Straps
  input  wire [WIDTH-1:0] strap_pins,
  output wire [WIDTH-1:0] captured
);

  wire [WIDTH-1:0] level;
  wire [WIDTH-1:0] stable;
  reg  [WIDTH-1:0] cap_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_sync
      strap_sync u_sync (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pin_in     (strap_pins[i]),
        .level_out  (level[i]),
        .stable_out (stable[i])
      );
    end
  endgenerate

  // Track only settled pins while reset holds, then freeze
  integer k;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_reg <= `STRAP_RESET;
    end else if (dev_reset_active) begin
      for (k = 0; k < WIDTH; k = k + 1) begin
        if (stable[k]) begin
          cap_reg[k] <= level[k];
        end
      end
    end
  end

  assign captured = cap_reg;

endmodule

// [logic/device_status_block.v]
// Device status register: reset strap capture behind an AHB-Lite slave
//
// Our own choice: the AHB-Lite slave port.
`include "device_status_regs.vh"

module device_status_block (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Strap pins
  input  wire        ext_mem_pins_on,
  input  wire        sdram_ctrl_pins_on,
  input  wire        pci_pin_select,
  input  wire [2:0]  config_gp_inputs,
  input  wire        clock_out_pin_select,
  input  wire        serial_port1_pins_on,
  input  wire        pci_fast_clock,
  input  wire        pci_eeprom_autoinit,
  input  wire [1:0]  mac_interface_select,
  input  wire        little_endian_flag,
  input  wire        host_port_width,
  input  wire        ext_mem_clock_select,
  input  wire [3:0]  boot_selection
);

  // ----------------------------------------
  // Device reset window
  // ----------------------------------------
  // Stays high from reset until the strap pipeline has settled
  localparam [2:0] SETTLE_CYCLES = `SETTLE_CYCLES;
  reg  [2:0]  settle_reg;
  wire        dev_reset_active;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_reg <= 3'h0;
    end else if (dev_reset_active) begin
      settle_reg <= settle_reg + 3'h1;
    end
  end

  assign dev_reset_active = (settle_reg != SETTLE_CYCLES);

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  wire [`STRAP_W-1:0] strap_pins;
  wire [`STRAP_W-1:0] cap;

  assign strap_pins = {ext_mem_pins_on, sdram_ctrl_pins_on, pci_pin_select, config_gp_inputs,
                       clock_out_pin_select, serial_port1_pins_on, pci_fast_clock,
                       pci_eeprom_autoinit, mac_interface_select, little_endian_flag,
                       host_port_width, ext_mem_clock_select, boot_selection};

  strap_capture #(
    .WIDTH (`STRAP_W)
  ) u_capture (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .dev_reset_active (dev_reset_active),
    .strap_pins       (strap_pins),
    .captured         (cap)
  );

  // ----------------------------------------
  // Register image
  // ----------------------------------------
  wire [31:0] device_status;

  assign device_status[`DS_RSVD_HI_MSB:`DS_RSVD_HI_LSB]   = `RSVD_HI_VALUE;
  assign device_status[`DS_EXT_MEM_PINS_ON]               = cap[18];
  assign device_status[`DS_SDRAM_CTRL_PINS_ON]            = cap[17];
  assign device_status[`DS_PCI_PIN_SELECT]                = cap[16];
  assign device_status[`DS_CONFIG_GP_MSB:`DS_CONFIG_GP_LSB] = cap[15:13];
  assign device_status[`DS_RSVD_ONE_HI]                   = `RSVD_ONE_VALUE;
  assign device_status[`DS_CLOCK_OUT_PIN_SELECT]          = cap[12];
  assign device_status[`DS_SERIAL_PORT1_PINS_ON]          = cap[11];
  assign device_status[`DS_PCI_FAST_CLOCK]                = cap[10];
  assign device_status[`DS_RSVD_ZERO_12]                  = `RSVD_ZERO_VALUE;
  assign device_status[`DS_PCI_EEPROM_AUTOINIT]           = cap[9];
  assign device_status[`DS_MAC_SEL_MSB:`DS_MAC_SEL_LSB]   = cap[8:7];
  assign device_status[`DS_RSVD_ONE_LO]                   = `RSVD_ONE_VALUE;
  assign device_status[`DS_RSVD_ZERO_7]                   = `RSVD_ZERO_VALUE;
  assign device_status[`DS_LITTLE_ENDIAN_FLAG]            = cap[6];
  assign device_status[`DS_HOST_PORT_WIDTH]               = cap[5];
  assign device_status[`DS_EXT_MEM_CLOCK_SELECT]          = cap[4];
  assign device_status[`DS_BOOT_SEL_MSB:`DS_BOOT_SEL_LSB] = cap[3:0];

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // Zero wait states; writes are ignored everywhere
  wire xfer;
  wire rd_hit;

  assign xfer   = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  assign rd_hit = xfer & ~hwrite & (haddr == `DEVICE_STATUS_ADDR);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `READ_ZERO;
    end else if (rd_hit) begin
      hrdata <= device_status;
    end else if (xfer) begin
      hrdata <= `READ_ZERO;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = `HRESP_OKAY;

endmodule

// [sim/device_status_asserts.sv]
// Checker for the device status block, bound to its ports
`include "device_status_regs.vh"
module device_status_asserts (
  // Bus, with the mac_interface_select and config_gp_inputs straps
  input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [1:0]  htrans, mac_interface_select,
  input wire logic [2:0]  hsize, config_gp_inputs,
  // Straps
  input wire logic [3:0]  boot_selection,
  input wire logic        ext_mem_pins_on, sdram_ctrl_pins_on, pci_pin_select, clock_out_pin_select,
  input wire logic        serial_port1_pins_on, pci_fast_clock, pci_eeprom_autoinit, little_endian_flag,
  input wire logic        host_port_width, ext_mem_clock_select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]  cnt;
  logic [18:0] snap;
  wire  [18:0] s = {ext_mem_pins_on, sdram_ctrl_pins_on, pci_pin_select, config_gp_inputs, clock_out_pin_select,
    serial_port1_pins_on, pci_fast_clock, pci_eeprom_autoinit, mac_interface_select, little_endian_flag,
    host_port_width, ext_mem_clock_select, boot_selection};
  wire rd = hsel && hready && htrans[1] && !hwrite && haddr == `DEVICE_STATUS_ADDR;
  wire ok = rd && cnt == 3'h7;
  // ----------------------------------------
  // Cycles since release, strap snapshot
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt <= 3'h0;
    else if (cnt != 3'h7) cnt <= cnt + 3'h1;
  end
  always @(posedge hclk) begin
    if (cnt == 3'h3) snap <= s;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rsvd; rd |=> hrdata[31:23] == 9'h000 && hrdata[16] && !hrdata[12] && hrdata[8:7] == 2'h2; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong");
  property p_mem; ok |=> hrdata[22:21] == snap[18:17]; endproperty
  a_mem: assert property (p_mem) else $error("memory pin bits wrong");
  property p_pci; ok |=> {hrdata[20], hrdata[13], hrdata[11]} == {snap[16], snap[10], snap[9]}; endproperty
  a_pci: assert property (p_pci) else $error("pci bits wrong");
  property p_gp; ok |=> hrdata[19:17] == snap[15:13]; endproperty
  a_gp: assert property (p_gp) else $error("config inputs wrong");
  property p_pins; ok |=> hrdata[15:14] == snap[12:11]; endproperty
  a_pins: assert property (p_pins) else $error("pin function bits wrong");
  property p_mac; ok |=> hrdata[10:9] == snap[8:7]; endproperty
  a_mac: assert property (p_mac) else $error("mac mode wrong");
  property p_mode; ok |=> hrdata[6:4] == snap[6:4]; endproperty
  a_mode: assert property (p_mode) else $error("endian width clock bits wrong");
  property p_boot; ok |=> hrdata[3:0] == snap[3:0]; endproperty
  a_boot: assert property (p_boot) else $error("boot selection wrong");
  c_read: cover property (ok);
  c_write: cover property (hsel && htrans[1] && hwrite);
  c_rst: cover property ($rose(hresetn));
endmodule

bind device_status_block device_status_asserts u_chk (.*);

// [sim/strap_board.sv]
// Board strap model driving the configuration pins
module strap_board (
  input  wire logic [18:0] choice,
  input  wire logic        disturb,
  output logic      [18:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Chosen levels, or the inverse once capture is over
  assign pins = disturb ? ~choice : choice;
endmodule

// [sim/testbench.sv]
// Testbench for the device status block
`include "device_status_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, disturb = 0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h0000ca20;
  logic [18:0] choice = 19'h0, pins;
  wire         hreadyout, hresp;
  int          err_count = 0, n_tests = 0;
  always #4 hclk = ~hclk;
  strap_board u_strap_board (.choice(choice), .disturb(disturb), .pins(pins));
  device_status_block u_device_status_block (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_mem_pins_on(pins[18]), .sdram_ctrl_pins_on(pins[17]),
    .pci_pin_select(pins[16]), .config_gp_inputs(pins[15:13]), .clock_out_pin_select(pins[12]),
    .serial_port1_pins_on(pins[11]), .pci_fast_clock(pins[10]), .pci_eeprom_autoinit(pins[9]),
    .mac_interface_select(pins[8:7]), .little_endian_flag(pins[6]), .host_port_width(pins[5]),
    .ext_mem_clock_select(pins[4]), .boot_selection(pins[3:0]));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [31:0] img(input logic [18:0] s);
    return {9'h000, s[18:13], 1'h1, s[12:10], 1'h0, s[9:7], 2'h2, s[6:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic results;
    $display("errors %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Straps per round: all four mac_interface_select modes, all boot codes
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      hresetn <= 1'b0;
      disturb <= 1'b0;
      choice <= (i == 0) ? 19'h00000 : {seed[18:9], i[1:0], seed[6:4], i[3:0]};
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
      xfer(`DEVICE_STATUS_ADDR, 1'b0, 32'h0);
      chk(rd, img(choice));
      xfer(`DEVICE_STATUS_ADDR, 1'b1, xs(seed));
      disturb <= 1'b1;
      xfer(`DEVICE_STATUS_ADDR, 1'b0, 32'h0);
      chk(rd, img(choice));
      xfer(`DEVICE_STATUS_ADDR + 32'h4, 1'b0, 32'h0);
      chk(rd, 32'h00000000);
    end
    results();
  end
  initial begin
    #100000;
    err_count++;
    results();
  end
endmodule
